/* src/converter_reset_and_load_meter.v */
// Reset sequencing, fast power-down, low-power mode and load-current metering
// of a multi-phase step-down converter, with its two-wire register port.
// Assumes bus, reset, sleep, supply and fault pins are asynchronous; OTP and analog current values are on core_clk_i.
// How it works
// - Selection write starts a new measurement
// - Measurement lasts at least 50 us
// - Start clears ready flag; reset value zero
// - Completion sets ready flag
// - Result split: low byte, high bits in selection
// - Result LSB 10 mA, capped at 20 A
// - Ready raises interrupt unless mask bit set
// - Control bit enables low-power pulse mode
// - Sleep request enables low-power pulse mode
// - After power-on reset read OTP, then standby
// - Converter follows enable bit and reset pin
// - Soft reset on write one then zero
// - Soft reset keeps fault flags
// - Power-on reset on supply rise or toggle
// - Registers keep value until written or flagged
// - Reset pin low restores control defaults
// - Fast power-down on faults or I/O supply loss with reset pin high
// - Memory reload finishes within 25 us
// - Interrupt low while any fault flag or unmasked ready flag set
`timescale 1ns/1ps
`include "converter_reset_and_load_meter_regs.vh"

module converter_reset_and_load_meter #(
  parameter MEAS_CYCLES = `MEAS_CYCLES
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  input wire hw_reset_pin_n_i,
  input wire sleep_request_n_i,
  input wire io_supply_input_i,
  input wire analog_supply_input_i,
  input wire ovp_i,
  input wire uvlo_i,
  input wire thsd_i,
  input wire [7:0] otp_vset_i,
  input wire [10:0] load_current_value_i,
  output reg [2:0] meas_select_o,
  output reg meas_busy_o,
  output reg converter_on_o,
  output reg low_power_pfm_o,
  output reg fast_pd_o,
  output reg int_n_o,
  output reg standby_o
);

  localparam ST_POR = 3'h0;
  localparam ST_LOAD = 3'h1;
  localparam ST_STBY = 3'h2;
  localparam ST_HWRST = 3'h3;
  localparam BS_IDLE = 2'h0;
  localparam BS_REG = 2'h1;
  localparam BS_WR = 2'h2;
  localparam BS_RD = 2'h3;

  // Pin synchronisers, three stages, accept when stages two and three agree
  reg [8:0] s1_q;
  reg [8:0] s2_q;
  reg [8:0] s3_q;
  reg [8:0] pin_q;
  reg [8:0] pin_p_q;
  wire [8:0] pins_raw;
  assign pins_raw = {thsd_i, uvlo_i, ovp_i, analog_supply_input_i, io_supply_input_i,
                     sleep_request_n_i, hw_reset_pin_n_i, sda_i, scl_i};

  integer k;
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      s1_q <= `PIN_RESET;
      s2_q <= `PIN_RESET;
      s3_q <= `PIN_RESET;
      pin_q <= `PIN_RESET;
      pin_p_q <= `PIN_RESET;
    end else begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (k = 0; k < 9; k = k + 1) begin
        if (s2_q[k] == s3_q[k]) begin
          pin_q[k] <= s3_q[k];
        end
      end
      pin_p_q <= pin_q;
    end
  end

  wire scl = pin_q[0];
  wire sda = pin_q[1];
  wire hw_reset_pin_n = pin_q[2];
  wire sleep_n = pin_q[3];
  wire io_ok = pin_q[4];
  wire ana_ok = pin_q[5];
  wire scl_rise = scl & ~pin_p_q[0];
  wire scl_fall = ~scl & pin_p_q[0];
  wire bus_start = scl & pin_p_q[0] & ~sda & pin_p_q[1];
  wire bus_stop = scl & pin_p_q[0] & sda & ~pin_p_q[1];
  // Supply rising or I/O supply toggled low/high
  wire por_evt = (ana_ok & ~pin_p_q[5]) | (io_ok & ~pin_p_q[4]);
  wire supply_lost = ~ana_ok | ~io_ok;
  wire fpd_cond = pin_q[6] | pin_q[7] | pin_q[8] | (~io_ok & hw_reset_pin_n);

  // Sequencer
  reg [2:0] state_q;
  reg [12:0] rl_cnt_q;
  reg por_load_q;
  wire load_done = (state_q == ST_LOAD) && (rl_cnt_q == `RELOAD_CYCLES - 1);
  wire por_clr = (state_q == ST_POR);
  wire hw_clr = (state_q == ST_HWRST);

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= ST_POR;
      rl_cnt_q <= 13'h0000;
      por_load_q <= 1'b1;
    end else if (supply_lost || por_evt) begin
      state_q <= ST_POR;
      rl_cnt_q <= 13'h0000;
      por_load_q <= 1'b1;
    end else begin
      case (state_q)
        ST_POR: begin
          state_q <= ST_LOAD;
          rl_cnt_q <= 13'h0000;
        end
        ST_LOAD: begin
          rl_cnt_q <= rl_cnt_q + 13'h0001;
          if (load_done) begin
            state_q <= ST_STBY;
            por_load_q <= 1'b0;
          end
        end
        ST_STBY: begin
          if (!hw_reset_pin_n) begin
            state_q <= ST_HWRST;
          end
        end
        ST_HWRST: begin
          if (hw_reset_pin_n) begin
            state_q <= ST_LOAD;
            rl_cnt_q <= 13'h0000;
          end
        end
        default: begin
          state_q <= ST_POR;
        end
      endcase
    end
  end

  // Two-wire register port
  reg [1:0] bs_q;
  reg [3:0] bc_q;
  reg [7:0] sh_q;
  reg [7:0] tx_q;
  reg [7:0] ptr_q;
  reg rd_q;
  reg wr_stb_q;
  reg [7:0] wr_addr_q;
  reg [7:0] wr_data_q;
  reg [7:0] rd_data;

  always @(posedge core_clk_i) begin
    if (rst_i || por_clr) begin
      bs_q <= BS_IDLE;
      bc_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rd_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      sda_oe_o <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      if (bus_start) begin
        bs_q <= BS_IDLE;
        bc_q <= 4'h0;
        rd_q <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (bus_stop) begin
        bs_q <= BS_IDLE;
        bc_q <= 4'hF;
        sda_oe_o <= 1'b0;
      end else if (scl_rise && bc_q != 4'hF) begin
        if (bc_q < 4'h8) begin
          sh_q <= {sh_q[6:0], sda};
          bc_q <= bc_q + 4'h1;
        end else if (bc_q == 4'h8) begin
          bc_q <= 4'h9;
          if (bs_q == BS_RD && rd_q && sda) begin
            bc_q <= 4'hF;
          end
        end
      end else if (scl_fall && bc_q != 4'hF) begin
        if (bc_q == 4'h8) begin
          if (rd_q) begin
            sda_oe_o <= 1'b0;
          end else if (bs_q == BS_IDLE) begin
            if (sh_q[7:1] == `BUS_ADDR) begin
              sda_oe_o <= 1'b1;
              rd_q <= sh_q[0];
              bs_q <= sh_q[0] ? BS_RD : BS_REG;
            end else begin
              bc_q <= 4'hF;
            end
          end else if (bs_q == BS_REG) begin
            ptr_q <= sh_q;
            sda_oe_o <= 1'b1;
            bs_q <= BS_WR;
          end else begin
            wr_stb_q <= 1'b1;
            wr_addr_q <= ptr_q;
            wr_data_q <= sh_q;
            ptr_q <= ptr_q + 8'h01;
            sda_oe_o <= 1'b1;
          end
        end else if (bc_q == 4'h9) begin
          bc_q <= 4'h0;
          sda_oe_o <= 1'b0;
          if (rd_q) begin
            tx_q <= rd_data;
            ptr_q <= ptr_q + 8'h01;
            sda_oe_o <= ~rd_data[7];
          end
        end else if (rd_q && bc_q != 4'h0) begin
          sda_oe_o <= ~tx_q[3'h7 - bc_q[2:0]];
        end
      end
    end
  end

  // Registers
  reg [7:0] vset_q;
  reg [7:0] general_q;
  reg sw_bit_q;
  reg sw_arm_q;
  reg [7:0] delay_q;
  reg [3:0] flags_q;
  reg [2:0] sel_q;
  reg [10:0] result_q;
  reg [7:0] mask2_q;
  reg [12:0] meas_cnt_q;

  wire wr_sel = wr_stb_q && wr_addr_q == `REG_SEL;
  wire wr_rst = wr_stb_q && wr_addr_q == `REG_RESET;
  wire sw_rst = wr_rst && !wr_data_q[`RESET_SW_BIT] && sw_arm_q;
  wire meas_done = meas_busy_o && meas_cnt_q == MEAS_CYCLES - 1;
  wire [3:0] flag_set = {meas_done, pin_q[8], pin_q[7], pin_q[6]};
  wire [3:0] flag_w1c = (wr_stb_q && wr_addr_q == `REG_FLAGS2) ? wr_data_q[3:0] : 4'h0;

  always @* begin
    case (ptr_q)
      `REG_VSET: rd_data = vset_q;
      `REG_GENERAL: rd_data = general_q;
      `REG_RESET: rd_data = {7'h00, sw_bit_q};
      `REG_DELAY: rd_data = delay_q;
      `REG_FLAGS2: rd_data = {4'h0, flags_q};
      `REG_SEL: rd_data = {result_q[10:8], 2'h0, sel_q};
      `REG_RESULT: rd_data = result_q[7:0];
      `REG_MASK2: rd_data = mask2_q;
      default: rd_data = 8'h00;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (rst_i || por_clr) begin
      vset_q <= `RESET_VAL;
      general_q <= `RESET_VAL;
      sw_bit_q <= 1'b0;
      sw_arm_q <= 1'b0;
      delay_q <= `RESET_VAL;
      flags_q <= 4'h0;
      sel_q <= 3'h0;
      result_q <= 11'h000;
      mask2_q <= `RESET_VAL;
      meas_cnt_q <= 13'h0000;
      meas_busy_o <= 1'b0;
      meas_select_o <= 3'h0;
    end else begin
      // Flags: hardware set wins over host clear; untouched by soft/hw reset
      flags_q <= (flags_q & ~flag_w1c) | flag_set;
      if (load_done && por_load_q) begin
        vset_q <= otp_vset_i;
      end
      if (hw_clr || sw_rst) begin
        general_q <= `RESET_VAL;
        delay_q <= `RESET_VAL;
        mask2_q <= `RESET_VAL;
        sw_arm_q <= 1'b0;
        if (hw_clr) begin
          sw_bit_q <= 1'b0;
        end else begin
          sw_bit_q <= wr_data_q[`RESET_SW_BIT];
        end
      end else if (wr_stb_q) begin
        sw_arm_q <= wr_rst && wr_data_q[`RESET_SW_BIT];
        case (wr_addr_q)
          `REG_VSET: vset_q <= wr_data_q;
          `REG_GENERAL: general_q <= wr_data_q;
          `REG_RESET: sw_bit_q <= wr_data_q[`RESET_SW_BIT];
          `REG_DELAY: delay_q <= wr_data_q;
          `REG_SEL: sel_q <= wr_data_q[`SEL_MSB:0];
          `REG_MASK2: mask2_q <= wr_data_q;
          default: sw_bit_q <= sw_bit_q;
        endcase
      end
      // Measurement sequence
      if (wr_sel) begin
        meas_busy_o <= 1'b1;
        meas_cnt_q <= 13'h0000;
        meas_select_o <= wr_data_q[`SEL_MSB:0];
        flags_q[`FLAG_RDY_BIT] <= 1'b0;
      end else if (meas_busy_o) begin
        meas_cnt_q <= meas_cnt_q + 13'h0001;
        if (meas_done) begin
          meas_busy_o <= 1'b0;
          if (load_current_value_i > `RESULT_MAX) begin
            result_q <= `RESULT_MAX;
          end else begin
            result_q <= load_current_value_i;
          end
        end
      end
    end
  end

  // Output stage
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
      converter_on_o <= 1'b0;
      low_power_pfm_o <= 1'b0;
      fast_pd_o <= 1'b0;
      int_n_o <= 1'b1;
      standby_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      standby_o <= state_q == ST_STBY;
      converter_on_o <= state_q == ST_STBY && vset_q[`VSET_EN_BIT] && hw_reset_pin_n
                        && !fpd_cond && !supply_lost;
      low_power_pfm_o <= general_q[`GEN_LP_BIT] || !sleep_n;
      fast_pd_o <= fpd_cond;
      int_n_o <= !(flags_q[2:0] != 3'h0
                   || (flags_q[`FLAG_RDY_BIT] && !mask2_q[`MASK_RDY_BIT]));
    end
  end

endmodule // converter_reset_and_load_meter

/* include/converter_reset_and_load_meter_regs.vh */
// Register map, field positions and timing counts of the converter control block.
// Assumes a 100 MHz core clock.
`ifndef CONVERTER_RESET_AND_LOAD_METER_REGS_VH
`define CONVERTER_RESET_AND_LOAD_METER_REGS_VH

`define REG_VSET 8'h00
`define REG_GENERAL 8'h10
`define REG_RESET 8'h11
`define REG_DELAY 8'h12
`define REG_FLAGS2 8'h0E
`define REG_SEL 8'h21
`define REG_RESULT 8'h22
`define REG_MASK2 8'h2E

`define VSET_EN_BIT 7
`define GEN_LP_BIT 0
`define RESET_SW_BIT 0
`define FLAG_OVP_BIT 0
`define FLAG_UVLO_BIT 1
`define FLAG_THSD_BIT 2
`define FLAG_RDY_BIT 3
`define MASK_RDY_BIT 0
`define SEL_MSB 2
`define SEL_HI_LSB 5

`define RESET_VAL 8'h00
`define BUS_ADDR 7'h60
`define RESULT_MAX 11'h7D0

`define CLK_PERIOD_NS 10
`define MEAS_TIME_NS 50000
`define MEAS_CYCLES ((`MEAS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RELOAD_TIME_NS 20000
`define RELOAD_CYCLES (`RELOAD_TIME_NS / `CLK_PERIOD_NS)

`define PIN_RESET 9'h00F

`endif

/* verification/load_meter_chk.sv */
// Port assertions for the converter reset and load meter block.
// Bound to every instance of the design top; one core clock.
`timescale 1ns/1ps
module load_meter_chk #(
  parameter MEAS_CYCLES = 5000
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire hw_reset_pin_n_i,
  input wire sleep_request_n_i,
  input wire io_supply_input_i,
  input wire ovp_i,
  input wire uvlo_i,
  input wire thsd_i,
  input wire meas_busy_o,
  input wire converter_on_o,
  input wire low_power_pfm_o,
  input wire fast_pd_o,
  input wire int_n_o,
  input wire standby_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  reg [15:0] busy_q;
  reg [15:0] wait_q;
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      busy_q <= 16'h0000;
      wait_q <= 16'h0000;
    end else begin
      busy_q <= meas_busy_o ? busy_q + 16'h0001 : 16'h0000;
      wait_q <= (standby_o || !hw_reset_pin_n_i || !io_supply_input_i) ? 16'h0000 :
        wait_q + 16'h0001;
    end
  end
  sequence s_fault_held;
    (ovp_i || uvlo_i || thsd_i || (!io_supply_input_i && hw_reset_pin_n_i)) [*8];
  endsequence
  a_busy_min_len: assert property ($fell(meas_busy_o) |-> busy_q >= MEAS_CYCLES - 1)
    else $error("measurement too short");
  a_reload_bound: assert property ($rose(standby_o) |-> wait_q <= 16'h09C4)
    else $error("reload too long");
  a_sleep_lp: assert property (!sleep_request_n_i [*8] |-> low_power_pfm_o)
    else $error("sleep without low power");
  a_fault_pd: assert property (s_fault_held |-> fast_pd_o)
    else $error("no fast power-down");
  a_pd_conv_off: assert property (fast_pd_o [*2] |-> !converter_on_o)
    else $error("converter on in power-down");
  a_hw_reset_pin_n_off: assert property (!hw_reset_pin_n_i [*6] |-> !converter_on_o)
    else $error("converter on in reset");
  a_thsd_int: assert property (thsd_i [*8] |-> !int_n_o)
    else $error("no interrupt on fault");
  a_reset_idle: assert property ($past(rst_i) |-> int_n_o && !meas_busy_o)
    else $error("outputs not idle after reset");
endmodule // load_meter_chk

bind converter_reset_and_load_meter load_meter_chk #(.MEAS_CYCLES(MEAS_CYCLES)) i_chk (
  .core_clk_i, .rst_i, .hw_reset_pin_n_i, .sleep_request_n_i, .io_supply_input_i,
  .ovp_i, .uvlo_i, .thsd_i, .meas_busy_o, .converter_on_o, .low_power_pfm_o,
  .fast_pd_o, .int_n_o, .standby_o);

/* verification/bus_host_model.sv */
// Two-wire bus host standing in for the application processor.
// Releases the data line as 1; the bench resolves the wire.
`timescale 1ns/1ps
module bus_host_model (
  input wire core_clk_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task hp;
    repeat (10) @(negedge core_clk_i);
  endtask
  task bx(input b, output r);
    sda_o = b;
    hp;
    scl_o = 1'b1;
    hp;
    r = sda_i;
    scl_o = 1'b0;
    repeat (2) @(negedge core_clk_i);
  endtask
  task start;
    sda_o = 1'b1;
    hp;
    scl_o = 1'b1;
    hp;
    sda_o = 1'b0;
    hp;
    scl_o = 1'b0;
    repeat (2) @(negedge core_clk_i);
  endtask
  task stop;
    sda_o = 1'b0;
    hp;
    scl_o = 1'b1;
    hp;
    sda_o = 1'b1;
    hp;
  endtask
  task xb(input [7:0] d, output [7:0] q, output ack);
    reg a;
    integer i;
    for (i = 7; i >= 0; i = i - 1) bx(d[i], q[i]);
    bx(1'b1, a);
    ack = !a;
  endtask
  task wr(input [7:0] r, input [7:0] d, output ok);
    reg [7:0] q;
    reg a1, a2, a3;
    start;
    xb(8'hC0, q, a1);
    xb(r, q, a2);
    xb(d, q, a3);
    stop;
    ok = a1 && a2 && a3;
  endtask
  task rd(input [7:0] r, output [7:0] v);
    reg [7:0] q;
    reg a;
    start;
    xb(8'hC0, q, a);
    xb(r, q, a);
    start;
    xb(8'hC1, q, a);
    xb(8'hFF, v, a);
    stop;
  endtask
endmodule // bus_host_model

/* verification/tb.sv */
// Self-checking bench of the converter reset and load meter block.
// Uses the bus host model; the port checker is bound to the design.
`timescale 1ns/1ps
module tb;
  reg core_clk_i = 1'b0, rst_i = 1'b1, hw_reset_pin_n_i = 1'b1, sleep_request_n_i = 1'b1;
  reg io_supply_input_i = 1'b1, analog_supply_input_i = 1'b1;
  reg ovp_i = 1'b0, uvlo_i = 1'b0, thsd_i = 1'b0, ok;
  reg [10:0] load_current_value_i = 11'h5A3;
  reg [7:0] v;
  wire scl_i, hsda, sda_o, sda_oe_o, meas_busy_o, converter_on_o, low_power_pfm_o;
  wire fast_pd_o, int_n_o, standby_o;
  wire [2:0] meas_select_o;
  wire sda_i = hsda & (sda_oe_o ? sda_o : 1'b1);
  integer fail_count = 0, num_checks = 0, cyc = 0, n;
  always #5 core_clk_i = ~core_clk_i;
  converter_reset_and_load_meter i_converter_reset_and_load_meter (
    .core_clk_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .hw_reset_pin_n_i,
    .sleep_request_n_i, .io_supply_input_i, .analog_supply_input_i, .ovp_i, .uvlo_i,
    .thsd_i, .otp_vset_i(8'h85), .load_current_value_i, .meas_select_o, .meas_busy_o,
    .converter_on_o, .low_power_pfm_o, .fast_pd_o, .int_n_o, .standby_o);
  bus_host_model i_host (.core_clk_i, .sda_i, .scl_o(scl_i), .sda_o(hsda));
  task summarize;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 99000) begin
      fail_count = fail_count + 1;
      summarize;
    end
  end
  task cmp(input [10:0] got, input [10:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rc(input [7:0] r, input [7:0] exp);
    i_host.rd(r, v);
    cmp(v, exp);
  endtask
  task w(input [7:0] r, input [7:0] d);
    i_host.wr(r, d, ok);
    cmp(ok, 1'b1);
  endtask
  task t(input integer c);
    repeat (c) @(negedge core_clk_i);
  endtask
  initial begin
    t(6);
    rst_i = 1'b0;
    t(50000);
    cmp(standby_o, 1'b1);
    cmp(converter_on_o, 1'b1);
    rc(8'h00, 8'h85);
    rc(8'h0E, 8'h00);
    rc(8'h30, 8'h00);
    w(8'h2E, 8'h00);
    w(8'h21, 8'h02);
    cmp(meas_busy_o, 1'b1);
    cmp(meas_select_o, 3'h2);
    rc(8'h0E, 8'h00);
    load_current_value_i = 11'h7FF;
    w(8'h21, 8'h01);
    t(2000);
    cmp(meas_busy_o, 1'b1);
    cmp(int_n_o, 1'b1);
    for (n = 0; n < 6000 && meas_busy_o !== 1'b0; n = n + 1) t(1);
    t(2);
    cmp(int_n_o, 1'b0);
    rc(8'h0E, 8'h08);
    rc(8'h22, 8'hD0);
    rc(8'h21, 8'hE1);
    w(8'h0E, 8'h08);
    cmp(int_n_o, 1'b1);
    w(8'h2E, 8'h01);
    load_current_value_i = 11'h123;
    w(8'h21, 8'h01);
    for (n = 0; n < 6000 && meas_busy_o !== 1'b0; n = n + 1) t(1);
    t(2);
    cmp(int_n_o, 1'b1);
    rc(8'h22, 8'h23);
    rc(8'h21, 8'h21);
    w(8'h10, 8'h01);
    w(8'h12, 8'h05);
    cmp(low_power_pfm_o, 1'b1);
    w(8'h11, 8'h01);
    w(8'h12, 8'h06);
    w(8'h11, 8'h00);
    cmp(low_power_pfm_o, 1'b1);
    w(8'h11, 8'h01);
    w(8'h11, 8'h00);
    t(2);
    cmp(low_power_pfm_o, 1'b0);
    rc(8'h12, 8'h00);
    rc(8'h0E, 8'h08);
    rc(8'h00, 8'h85);
    sleep_request_n_i = 1'b0;
    t(10);
    cmp(low_power_pfm_o, 1'b1);
    sleep_request_n_i = 1'b1;
    w(8'h10, 8'h01);
    hw_reset_pin_n_i = 1'b0;
    t(200);
    cmp(converter_on_o, 1'b0);
    cmp(fast_pd_o, 1'b0);
    hw_reset_pin_n_i = 1'b1;
    t(2510);
    cmp(standby_o, 1'b1);
    cmp(converter_on_o, 1'b1);
    rc(8'h10, 8'h00);
    for (n = 0; n < 3; n = n + 1) begin
      {ovp_i, uvlo_i, thsd_i} = 3'h1 << n;
      t(10);
      cmp(fast_pd_o, 1'b1);
      cmp(converter_on_o, 1'b0);
      cmp(int_n_o, 1'b0);
    end
    {ovp_i, uvlo_i, thsd_i} = 3'h0;
    rc(8'h0E, 8'h0F);
    analog_supply_input_i = 1'b0;
    t(10);
    cmp(standby_o, 1'b0);
    analog_supply_input_i = 1'b1;
    t(2510);
    cmp(standby_o, 1'b1);
    rc(8'h0E, 8'h00);
    io_supply_input_i = 1'b0;
    t(10);
    cmp(fast_pd_o, 1'b1);
    io_supply_input_i = 1'b1;
    t(2510);
    cmp(standby_o, 1'b1);
    cmp(int_n_o, 1'b1);
    summarize;
  end
endmodule // tb
